//--- verilog/tick_timer_pkg.sv
// Constants for the dual timebase capture timer
package tick_timer_pkg;
   localparam int unsigned CLOCK_HZ = 40000000;
   localparam int unsigned OSC_DIV = 32;
   localparam int unsigned PRESCALE_W = 5;
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 5'(OSC_DIV - 1);
   localparam logic [7:0] CNT_ONE_LAST = 8'hF9;
   localparam logic [7:0] CNT_ONE_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] CAPTURE_RESET = 8'h00;
   localparam logic [7:0] CNT_TWO_LAST = 8'hFF;
   localparam int unsigned CSR1_CAP_IE_BIT = 7;
   localparam int unsigned CSR1_CAP_FLAG_BIT = 6;
   localparam int unsigned CSR1_DOUBLE_BIT = 5;
   localparam int unsigned CSR1_ONE_IE_BIT = 4;
   localparam int unsigned CSR1_ONE_FLAG_BIT = 3;
   localparam int unsigned CSR2_TWO_IE_BIT = 1;
   localparam int unsigned CSR2_TWO_FLAG_BIT = 0;
   typedef enum logic [1:0] {
      PWR_RUN = 2'h0,
      PWR_WAIT = 2'h1,
      PWR_ACTIVE_HALT = 2'h3,
      PWR_HALT = 2'h2
   } power_mode_e;
endpackage

//--- verilog/capture_sync_if.sv
// Synchronised capture pin and its edge pulse
`timescale 1ns/1ps
interface capture_sync_if;
   logic level;
   logic edge_pulse;
   modport source (output level, output edge_pulse);
   modport sink (input level, input edge_pulse);
endinterface

//--- verilog/capture_edge_sync.sv
// Two-stage synchroniser and any-edge detector for the capture pin
`timescale 1ns/1ps
module capture_edge_sync
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_pin,
   capture_sync_if.source sync_port
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   assign sync_port.level = sync_reg;
   assign sync_port.edge_pulse = sync_reg ^ last_reg;
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
endmodule // capture_edge_sync

//--- verilog/dual_timebase_capture_timer.sv
// Dual timebase and input capture timer with plain register ports
//
// Contract
// - Counter one is hidden 8-bit, counts from zero at clock/32.
// - Counter one overflows wrapping F9h to 00h, dividing by 250.
// - Overflow period 1 ms at 8 MHz; double-select doubles it.
// - Counter one overflow sets tick-one flag; request when enabled.
// - Reading first control/status register clears tick-one flag.
// - Capture register latches counter one on any capture pin edge.
// - Capture sets capture flag; request when enabled; holds counter value.
// - Reading capture value register clears capture flag.
// - No capture while capture flag set; last value kept.
// - Counter two is 8-bit auto-reload, readable by software.
// - Counter two starts from reload value, counts at clock/32.
// - Counter two overflows past FFh and reloads.
// - Reload writes accepted anytime; used at next overflow.
// - Counter two period 4 us to 1.024 ms in 4 us steps.
// - Counter two overflow sets tick-two flag; second register read clears.
// - Enabled tick-one event wakes from wait and active-halt, not halt.
// - Tick-two and capture events wake from wait only.
// - Separate request lines, served when enabled and CPU mask clear.
// - Writes to event flags leave them unchanged.
`timescale 1ns/1ps
module dual_timebase_capture_timer
   import tick_timer_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_capture_input_pin,
   input wire tick_timer_pkg::power_mode_e i_power_mode,
   input wire logic i_cpu_irq_masked,
   input wire logic i_ctrl_status_first_wr,
   input wire logic [7:0] i_ctrl_status_first_wdata,
   input wire logic i_ctrl_status_first_rd,
   input wire logic i_ctrl_status_second_wr,
   input wire logic [7:0] i_ctrl_status_second_wdata,
   input wire logic i_ctrl_status_second_rd,
   input wire logic i_reload_value_wr,
   input wire logic [7:0] i_reload_value_wdata,
   input wire logic i_capture_value_rd,
   output logic [7:0] o_ctrl_status_first,
   output logic [7:0] o_ctrl_status_second,
   output logic [7:0] o_reload_value_reg,
   output logic [7:0] o_counter_two_value_reg,
   output logic [7:0] o_capture_value_reg,
   output logic o_tick_one_irq,
   output logic o_tick_two_irq,
   output logic o_capture_irq,
   output logic o_wakeup
);
   import tick_timer_pkg::*;

   function automatic logic [7:0] inc8(input logic [7:0] v);
      inc8 = 8'(v + 8'h01);
   endfunction

   // Hardware set wins over a clearing read in the same cycle
   function automatic logic sticky_next(input logic cur, input logic hw_set, input logic rd_clr);
      if (hw_set)
         sticky_next = 1'b1;
      else if (rd_clr)
         sticky_next = 1'b0;
      else
         sticky_next = cur;
   endfunction

   // A request only leaves the block while the CPU mask is clear
   function automatic logic gate_req(input logic flag, input logic enable, input logic masked);
      gate_req = flag && enable && !masked;
   endfunction

   capture_sync_if cap_if ();

   capture_edge_sync u_sync
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_pin(i_capture_input_pin),
      .sync_port(cap_if.source)
   );

   logic [PRESCALE_W-1:0] prescale_reg;
   logic [7:0] count_one_reg;
   logic period_half_reg;
   logic [7:0] count_two_reg;
   logic reload_seen_reg;
   logic [7:0] reload_reg;
   logic [7:0] capture_reg;
   logic capture_flag;
   logic capture_irq_en;
   logic tick_one_flag;
   logic tick_one_irq_en;
   logic period_double_sel;
   logic tick_two_flag;
   logic tick_two_irq_en;

   wire halted = (i_power_mode == PWR_HALT);
   wire tick_en = (prescale_reg == PRESCALE_LAST) && !halted;
   wire one_wrap = tick_en && (count_one_reg == CNT_ONE_LAST);
   wire one_event = one_wrap && (!period_double_sel || period_half_reg);
   wire two_event = tick_en && (count_two_reg == CNT_TWO_LAST);
   // any edge, inhibited while flag set
   wire capture_take = cap_if.edge_pulse && !capture_flag;
   wire [7:0] count_one_next = one_wrap ? CNT_ONE_RESET : inc8(count_one_reg);
   wire [7:0] count_two_next = two_event ? reload_reg : inc8(count_two_reg);

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         prescale_reg <= '0;
      else if (!halted)
         prescale_reg <= PRESCALE_W'(prescale_reg + 1'b1);
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count_one_reg <= CNT_ONE_RESET;
         period_half_reg <= 1'b0;
      end
      else if (tick_en)
      begin
         count_one_reg <= count_one_next;
         if (one_wrap)
            period_half_reg <= !period_half_reg;
      end
   end

   // first reload after reset, then count, reload at overflow
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count_two_reg <= RELOAD_RESET;
         reload_seen_reg <= 1'b0;
      end
      else if (!reload_seen_reg)
      begin
         count_two_reg <= reload_reg;
         reload_seen_reg <= 1'b1;
      end
      else if (tick_en)
         count_two_reg <= count_two_next;
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         reload_reg <= RELOAD_RESET;
      else if (i_reload_value_wr)
         reload_reg <= i_reload_value_wdata;
   end

   // Enable and double-select bits; flag bits of written data are ignored
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         capture_irq_en <= 1'b0;
         period_double_sel <= 1'b0;
         tick_one_irq_en <= 1'b0;
         tick_two_irq_en <= 1'b0;
      end
      else
      begin
         if (i_ctrl_status_first_wr)
         begin
            capture_irq_en <= i_ctrl_status_first_wdata[CSR1_CAP_IE_BIT];
            period_double_sel <= i_ctrl_status_first_wdata[CSR1_DOUBLE_BIT];
            tick_one_irq_en <= i_ctrl_status_first_wdata[CSR1_ONE_IE_BIT];
         end
         if (i_ctrl_status_second_wr)
            tick_two_irq_en <= i_ctrl_status_second_wdata[CSR2_TWO_IE_BIT];
      end
   end

   // overflow sets a flag; status read clears it
   // flags take no write data at all
   wire tick_one_flag_next = sticky_next(tick_one_flag, one_event, i_ctrl_status_first_rd);
   wire tick_two_flag_next = sticky_next(tick_two_flag, two_event, i_ctrl_status_second_rd);
   // capture value read clears the capture flag
   wire capture_flag_next = sticky_next(capture_flag, capture_take, i_capture_value_rd);
   // capture register holds counter one at the taken edge
   wire [7:0] capture_next = capture_take ? count_one_reg : capture_reg;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         tick_one_flag <= 1'b0;
      else
         tick_one_flag <= tick_one_flag_next;
   end

   // tick two flag
   // A read in the overflow cycle loses, so no event goes unseen
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         tick_two_flag <= 1'b0;
      else
         tick_two_flag <= tick_two_flag_next;
   end

   // capture value and flag
   // Flag resets to zero here; software still reads once
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         capture_reg <= CAPTURE_RESET;
         capture_flag <= 1'b0;
      end
      else
      begin
         capture_reg <= capture_next;
         capture_flag <= capture_flag_next;
      end
   end

   // each source keeps its own request
   wire tick_one_req = tick_one_flag && tick_one_irq_en;
   wire tick_two_req = tick_two_flag && tick_two_irq_en;
   wire capture_req = capture_flag && capture_irq_en;
   // wake sources depend on power mode
   wire wake_any = (i_power_mode == PWR_WAIT) && (tick_one_req || tick_two_req || capture_req);
   wire wake_ah = (i_power_mode == PWR_ACTIVE_HALT) && tick_one_req;
   // Halt has no wake source: the counters are frozen there
   // Wake ignores the CPU mask, which only gates servicing
   wire wake_next = wake_any || wake_ah;

   // Status words as software reads them; unused bits read zero
   wire [7:0] status_first_word = {capture_irq_en, capture_flag, period_double_sel,
                                   tick_one_irq_en, tick_one_flag, 3'h0};
   wire [7:0] status_second_word = {6'h00, tick_two_irq_en, tick_two_flag};

   // Registered status words
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_ctrl_status_first <= 8'h00;
         o_ctrl_status_second <= 8'h00;
      end
      else
      begin
         o_ctrl_status_first <= status_first_word;
         o_ctrl_status_second <= status_second_word;
      end
   end

   // counter two and value registers seen by software
   // Mirrors trail the counters by one cycle, as do all outputs
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reload_value_reg <= RELOAD_RESET;
         o_counter_two_value_reg <= RELOAD_RESET;
         o_capture_value_reg <= CAPTURE_RESET;
      end
      else
      begin
         o_reload_value_reg <= reload_reg;
         o_counter_two_value_reg <= count_two_reg;
         o_capture_value_reg <= capture_reg;
      end
   end

   // request lines gated by the CPU mask
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_tick_one_irq <= 1'b0;
         o_tick_two_irq <= 1'b0;
         o_capture_irq <= 1'b0;
      end
      else
      begin
         o_tick_one_irq <= gate_req(tick_one_flag, tick_one_irq_en, i_cpu_irq_masked);
         o_tick_two_irq <= gate_req(tick_two_flag, tick_two_irq_en, i_cpu_irq_masked);
         o_capture_irq <= gate_req(capture_flag, capture_irq_en, i_cpu_irq_masked);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_wakeup <= 1'b0;
      else
         o_wakeup <= wake_next;
   end
endmodule // dual_timebase_capture_timer

//--- tb/tick_timer_asserts.sv
// Port-level assertions for the dual timebase capture timer
`timescale 1ns/1ps
module tick_timer_asserts
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire tick_timer_pkg::power_mode_e i_power_mode,
   input wire logic i_ctrl_status_first_rd,
   input wire logic i_ctrl_status_second_rd,
   input wire logic i_capture_value_rd,
   input wire logic [7:0] o_ctrl_status_first,
   input wire logic [7:0] o_ctrl_status_second,
   input wire logic [7:0] o_reload_value_reg,
   input wire logic [7:0] o_counter_two_value_reg,
   input wire logic [7:0] o_capture_value_reg,
   input wire logic o_tick_one_irq,
   input wire logic o_tick_two_irq,
   input wire logic o_capture_irq,
   input wire logic o_wakeup
);
   import tick_timer_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence halt_held;
      (i_power_mode == PWR_HALT) [*3];
   endsequence
   sequence cnt_step;
      $changed(o_counter_two_value_reg);
   endsequence
   a_one_irq_gate: assert property (o_tick_one_irq |-> o_ctrl_status_first[4:3] == 2'h3)
      else $error("tick one request without flag and enable");
   a_two_irq_gate: assert property (o_tick_two_irq |-> o_ctrl_status_second[1:0] == 2'h3)
      else $error("tick two request without flag and enable");
   a_cap_irq_gate: assert property (o_capture_irq |-> o_ctrl_status_first[7:6] == 2'h3)
      else $error("capture request without flag and enable");
   a_one_rd_clear: assert property (i_ctrl_status_first_rd && o_ctrl_status_first[3] |-> ##[1:2] !o_ctrl_status_first[3])
      else $error("tick one flag kept after read");
   a_two_rd_clear: assert property (i_ctrl_status_second_rd && o_ctrl_status_second[0] |-> ##[1:2] !o_ctrl_status_second[0])
      else $error("tick two flag kept after read");
   a_cap_rd_clear: assert property (i_capture_value_rd && o_ctrl_status_first[6] |-> ##[1:2] !o_ctrl_status_first[6])
      else $error("capture flag kept after read");
   a_cap_value_hold: assert property (o_ctrl_status_first[6] && $past(o_ctrl_status_first[6]) |-> $stable(o_capture_value_reg))
      else $error("capture value changed while flag set");
   a_cnt_step_reload: assert property (cnt_step |-> o_counter_two_value_reg == $past(o_counter_two_value_reg) + 8'h01
      || o_counter_two_value_reg == o_reload_value_reg)
      else $error("counter two moved other than step or reload");
   a_cnt_prescale: assert property (cnt_step |=> $stable(o_counter_two_value_reg) [*8])
      else $error("counter two stepped faster than prescaler");
   a_halt_stops: assert property (halt_held |=> $stable(o_counter_two_value_reg))
      else $error("counter two moved in halt");
   a_no_wake: assert property ((i_power_mode inside {PWR_HALT, PWR_RUN}) [*2] |=> !o_wakeup)
      else $error("wakeup raised in halt or run");
endmodule // tick_timer_asserts
bind dual_timebase_capture_timer tick_timer_asserts tick_timer_asserts_inst (.i_clock, .i_rst_n, .i_power_mode,
   .i_ctrl_status_first_rd, .i_ctrl_status_second_rd, .i_capture_value_rd, .o_ctrl_status_first,
   .o_ctrl_status_second, .o_reload_value_reg, .o_counter_two_value_reg, .o_capture_value_reg,
   .o_tick_one_irq, .o_tick_two_irq, .o_capture_irq, .o_wakeup);

//--- tb/cpu_side_model.sv
// Software side: one capture register read right after reset
`timescale 1ns/1ps
module cpu_side_model
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   output logic o_init_rd
);
   logic done_reg;
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         done_reg <= 1'b0;
         o_init_rd <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b1;
         o_init_rd <= !done_reg;
      end
   end
endmodule // cpu_side_model

//--- tb/tb.sv
// Self-checking bench for the dual timebase capture timer
`timescale 1ns/1ps
module tb;
   import tick_timer_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic pin = 1'b0;
   logic mask = 1'b1;
   power_mode_e mode = PWR_RUN;
   logic [5:0] stb = 6'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] seed = 8'h3C;
   logic [7:0] csr1, csr2, rld, cnt2, cap, keep;
   logic irq1, irq2, irqc, wake, init_rd;
   int cyc = 0;
   int miscompares = 0;
   int total_checks = 0;
   int t0, t1, t2;
   wire [2:0] fl = {csr1[6], csr2[0], csr1[3]};
   initial
   begin
      forever #12.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) cyc <= cyc + 1;
   dual_timebase_capture_timer dual_timebase_capture_timer_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_capture_input_pin(pin), .i_power_mode(mode), .i_cpu_irq_masked(mask), .i_ctrl_status_first_wr(stb[0]),
      .i_ctrl_status_first_wdata(wd), .i_ctrl_status_first_rd(stb[1]), .i_ctrl_status_second_wr(stb[2]),
      .i_ctrl_status_second_wdata(wd), .i_ctrl_status_second_rd(stb[3]), .i_reload_value_wr(stb[4]),
      .i_reload_value_wdata(wd), .i_capture_value_rd(stb[5] | init_rd), .o_ctrl_status_first(csr1),
      .o_ctrl_status_second(csr2), .o_reload_value_reg(rld), .o_counter_two_value_reg(cnt2),
      .o_capture_value_reg(cap), .o_tick_one_irq(irq1), .o_tick_two_irq(irq2), .o_capture_irq(irqc), .o_wakeup(wake));
   cpu_side_model cpu_side_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .o_init_rd(init_rd));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic int two_period(input logic [7:0] r);
      return (256 - r) * OSC_DIV;
   endfunction
   function automatic logic [7:0] cap_expect(input int dt);
      return 8'(((dt - 1) % (250 * OSC_DIV)) / OSC_DIV);
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Strobe k for one cycle, then let the outputs catch up
   task pulse(input int k, input logic [7:0] d);
      @(posedge i_clock);
      #2 stb[k] = 1'b1;
      wd = d;
      @(posedge i_clock);
      #2 stb = 6'h00;
      @(posedge i_clock);
      #2;
   endtask
   task set_in(input power_mode_e m, input logic mk);
      @(posedge i_clock);
      #2 mode = m;
      mask = mk;
      repeat (3) @(posedge i_clock);
      #1;
   endtask
   task wait_flag(input int k, output int t);
      int n;
      for (n = 0; n < 20000 && fl[k] !== 1'b1; n++)
      begin
         @(posedge i_clock);
         #1;
      end
      t = cyc;
      if (n == 20000)
      begin
         miscompares++;
         stop_test();
      end
   endtask
   initial
   begin
      repeat (12) @(posedge i_clock);
      #2 i_rst_n = 1'b1;
      @(posedge i_clock);
      #1 check({csr1, csr2}, 16'h0000);
      check({rld, cap}, 16'h0000);
      pulse(0, 8'hDF);
      pulse(2, 8'hFF);
      check({csr1, csr2}, 16'h9002);
      wait_flag(0, t0);
      pulse(1, 8'h00);
      check(fl[0], 1'b0);
      wait_flag(0, t1);
      check(16'(t1 - t0), 16'(250 * OSC_DIV));
      check(irq1, 1'b0);
      set_in(PWR_RUN, 1'b0);
      check(irq1, 1'b1);
      seed = lfsr(seed);
      repeat (seed) @(posedge i_clock);
      #2 pin = ~pin;
      wait_flag(2, t2);
      check(cap, cap_expect(t2 - t1));
      check(irqc, 1'b1);
      keep = cap;
      // Second edge comes once counter one has moved on
      repeat (40) @(posedge i_clock);
      #2 pin = ~pin;
      repeat (40) @(posedge i_clock);
      #1 check(cap, keep);
      pulse(5, 8'h00);
      check(fl[2], 1'b0);
      seed = lfsr(seed);
      pulse(4, seed);
      check(rld, seed);
      pulse(3, 8'h00);
      wait_flag(1, t0);
      check(cnt2, seed);
      pulse(4, 8'hFF);
      pulse(3, 8'h00);
      wait_flag(1, t1);
      check(16'(t1 - t0), 16'(two_period(seed)));
      pulse(3, 8'h00);
      wait_flag(1, t2);
      check({cnt2, 8'(t2 - t1)}, {8'hFF, 8'(two_period(8'hFF))});
      check(irq2, 1'b1);
      pulse(1, 8'h00);
      set_in(PWR_WAIT, 1'b0);
      check(wake, 1'b1);
      set_in(PWR_ACTIVE_HALT, 1'b0);
      check(wake, 1'b0);
      wait_flag(0, t0);
      #50 check(wake, 1'b1);
      set_in(PWR_HALT, 1'b0);
      keep = cnt2;
      repeat (100) @(posedge i_clock);
      #1 check({cnt2, 7'h00, wake}, {keep, 8'h00});
      set_in(PWR_RUN, 1'b0);
      pulse(0, 8'hB0);
      pulse(1, 8'h00);
      wait_flag(0, t0);
      pulse(1, 8'h00);
      wait_flag(0, t1);
      check(16'(t1 - t0), 16'(500 * OSC_DIV));
      stop_test();
   end
endmodule // tb
